// *** design/count_clock_gen.sv ***
// Count clock selector: turns the chosen source into one-cycle enable pulses.
// Assumes the high and sub clocks are derived from the system clock by dividers.
`timescale 1ns/1ps
module count_clock_gen
  import periodic_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic srst_i,
  // Control.
  input wire logic [2:0] count_clock_select_i,
  input wire logic ext_clock_pin_i,
  input wire logic capture_pin_i,
  // Events.
  timer_events_if.source ev
);
  logic [7:0] div_reg;
  logic ext_rise;
  logic ext_fall;

  // Free running prescaler; all divided rates are pulses from it.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  pin_edge_sync ext_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i(ext_clock_pin_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  pin_edge_sync cap_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i(capture_pin_i),
    .rise_o(ev.cap_rise),
    .fall_o(ev.cap_fall)
  );

  assign ev.ext_rise = ext_rise;
  assign ev.ext_fall = ext_fall;

  // Source selection for the count enable.
  always_comb begin
    case (count_clock_select_i)
      3'h0: ev.count_tick = (div_reg[1:0] == 2'(DIV_SYS4 - 1));
      3'h1: ev.count_tick = 1'b1;
      3'h2: ev.count_tick = (div_reg[3:0] == 4'(DIV_H16 - 1));
      3'h3: ev.count_tick = (div_reg[5:0] == 6'(DIV_H64 - 1));
      3'h4, 3'h5: ev.count_tick = (div_reg == 8'(DIV_SUB - 1));
      3'h6: ev.count_tick = ext_rise;
      3'h7: ev.count_tick = ext_fall;
      default: ev.count_tick = 1'b0;
    endcase
  end
endmodule // count_clock_gen

// *** design/periodic_timer.sv ***
// Periodic timer top: registers, 10-bit counter, comparators and output pin.
// Assumes a single-cycle register port and pins already routed to the timer.
// How it works
// - Ten-bit up-counter from selectable clock, compared against values A and P.
// - Software cannot write the count; a run rising edge is its only way to zero it.
// - Overflow or selected compare match clears counter and raises a flag.
// - Hold bit freezes the count; clearing it resumes from there.
// - Clock select picks divided system, high, sub clock or external edges.
// - Clearing run stops and keeps count; run rising edge zeroes it.
// - Run rising edge restores the output to its initial level in output modes.
// - Mode field picks compare, capture, PWM or single pulse, timer.
// - Compare mode: A match leaves, lowers, raises or toggles the pin.
// - PWM mode pin function: inactive, active, PWM wave, single pulse.
// - Capture mode pin function: rising, falling, both edges, disabled.
// - A match requesting the initial level shows no pin change.
// - Level control sets initial level or PWM active polarity.
// - Invert bit inverts the driven output pin.
// - Timer mode ignores pin function, level control and invert.
// - Clear source picks A match, or P match or overflow when P is zero.
// - Clear source is ignored in PWM, pulse and capture modes.
// - Count read-only as low and high bytes; compare values read/write pairs.
// - In compare mode only A match and the run rising edge move the pin.
// - Clearing on A never raises P flag; A zero wraps without A flag.
// - PWM period from P, zero means 1024; duty from A, saturating.
// - Single pulse starts on run rise; ends on run clear or A match.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module periodic_timer
  import periodic_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic srst_i,
  // Register port.
  input wire logic [periodic_timer_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Status register select (high selects the flag register).
  input wire logic status_sel_i,
  // Pins.
  input wire logic ext_clock_pin_i,
  input wire logic capture_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_o,
  // Events.
  output logic match_a_flag_o,
  output logic match_p_flag_o,
  output logic capture_event_o
);
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [9:0] count_reg;
  logic [9:0] cmp_a_reg;
  logic [9:0] cmp_p_reg;
  logic [9:0] capture_reg;
  logic run_q_reg;
  logic out_reg;
  logic pulse_reg;
  logic flag_a_reg;
  logic flag_p_reg;
  logic [7:0] rdata_reg;
  logic run;
  logic run_rise;
  logic hold;
  op_mode_t mode;
  logic [1:0] pin_fn;
  logic olc;
  logic inv;
  logic clr_a;
  logic tick;
  logic match_a;
  logic match_p;
  logic at_period;
  logic clear_now;
  logic cap_edge;
  logic sel_rise;
  logic sel_fall;
  logic pwm_level;
  logic wr_flags;
  timer_events_if ev ();

  count_clock_gen clk_gen (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .count_clock_select_i(ctrl0_reg[CLKSEL_LSB +: 3]),
    .ext_clock_pin_i(ext_clock_pin_i),
    .capture_pin_i(capture_pin_i),
    .ev(ev)
  );

  // Field decoding of the control registers.
  assign run = ctrl0_reg[RUN_BIT];
  assign hold = ctrl0_reg[HOLD_BIT];
  assign mode = op_mode_t'(ctrl1_reg[MODE_LSB +: 2]);
  assign pin_fn = ctrl1_reg[PINFN_LSB +: 2];
  assign olc = ctrl1_reg[OLC_BIT];
  assign inv = ctrl1_reg[INV_BIT];
  assign run_rise = run & ~run_q_reg;
  assign tick = ev.count_tick & run & ~hold;
  assign wr_flags = wr_i & status_sel_i;

  // Clear source applies only in compare and timer modes; others clear on P.
  assign clr_a = ctrl1_reg[CLRSRC_BIT] &
    ((mode == MODE_COMPARE) | (mode == MODE_TIMER));

  // Comparators fire as the counter reaches the compare value.
  assign match_a = tick & (cmp_a_reg != VAL_RESET) & (count_reg == cmp_a_reg);
  assign at_period = (cmp_p_reg == VAL_RESET) ? (count_reg == CNT_MAX) :
    (count_reg == cmp_p_reg - 10'h001);
  assign match_p = tick & ~clr_a & (cmp_p_reg != VAL_RESET) & (count_reg == cmp_p_reg);

  // Clear on P match/overflow or A match (A zero means wrap at full scale).
  always_comb begin
    if (mode == MODE_PWM) begin
      clear_now = tick & at_period;
    end else if (clr_a) begin
      clear_now = match_a;
    end else begin
      clear_now = match_p | (tick & (cmp_p_reg == VAL_RESET) & (count_reg == CNT_MAX));
    end
  end

  // Capture edge selection; source pin chosen by the capture source bit.
  assign sel_rise = ctrl1_reg[CAPSRC_BIT] ? ev.ext_rise : ev.cap_rise;
  assign sel_fall = ctrl1_reg[CAPSRC_BIT] ? ev.ext_fall : ev.cap_fall;
  always_comb begin
    case (pin_fn)
      2'h0: cap_edge = sel_rise;
      2'h1: cap_edge = sel_fall;
      2'h2: cap_edge = sel_rise | sel_fall;
      default: cap_edge = 1'b0;
    endcase
  end

  // Control registers; run edge detect trails by one cycle.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl0_reg <= CTRL_RESET;
      ctrl1_reg <= CTRL_RESET;
      run_q_reg <= 1'b0;
    end else begin
      run_q_reg <= run;
      if (wr_i && !status_sel_i && addr_i == REG_CTRL0) begin
        ctrl0_reg <= wdata_i & CTRL0_MASK;
      end else if (mode == MODE_PWM && pin_fn == 2'h3 && run && match_a) begin
        ctrl0_reg[RUN_BIT] <= 1'b0;
      end
      if (wr_i && !status_sel_i && addr_i == REG_CTRL1) begin
        ctrl1_reg <= wdata_i;
      end
    end
  end

  // Compare values are plain read/write pairs.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cmp_a_reg <= VAL_RESET;
      cmp_p_reg <= VAL_RESET;
    end else if (wr_i && !status_sel_i) begin
      case (addr_i)
        REG_CMPA_LO: cmp_a_reg[7:0] <= wdata_i;
        REG_CMPA_HI: cmp_a_reg[9:8] <= wdata_i[1:0];
        REG_CMPP_LO: cmp_p_reg[7:0] <= wdata_i;
        REG_CMPP_HI: cmp_p_reg[9:8] <= wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // Counter: no write path; run rise zeroes it, hold and off freeze it.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      count_reg <= VAL_RESET;
    end else if (run_rise) begin
      count_reg <= VAL_RESET;
    end else if (clear_now) begin
      count_reg <= VAL_RESET;
    end else if (tick) begin
      count_reg <= count_reg + 10'h001;
    end
  end

  // Capture latches the count on the chosen edge while running.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      capture_reg <= VAL_RESET;
    end else if (mode == MODE_CAPTURE && run && cap_edge) begin
      capture_reg <= count_reg;
    end
  end

  // Sticky flags; a new event wins over a software clear in the same cycle.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      if (match_a || (mode == MODE_CAPTURE && run && cap_edge)) begin
        flag_a_reg <= 1'b1;
      end else if (wr_flags && wdata_i[0]) begin
        flag_a_reg <= 1'b0;
      end
      if (match_p || (clear_now && !clr_a && mode != MODE_PWM && cmp_p_reg == VAL_RESET)) begin
        flag_p_reg <= 1'b1;
      end else if (mode == MODE_PWM && tick && at_period) begin
        flag_p_reg <= 1'b1;
      end else if (wr_flags && wdata_i[1]) begin
        flag_p_reg <= 1'b0;
      end
    end
  end

  // PWM level: active while count is below duty; duty at or above period is full.
  assign pwm_level = (count_reg < cmp_a_reg) |
    ((cmp_p_reg != VAL_RESET) & (cmp_a_reg >= cmp_p_reg));

  // Compare and single pulse output state; run rise loads both, A match moves them, run clear ends the pulse.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      out_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (run_rise) begin
      out_reg <= olc;
      pulse_reg <= 1'b1;
    end else if (mode == MODE_COMPARE && match_a) begin
      case (pin_fn)
        2'h1: out_reg <= 1'b0;
        2'h2: out_reg <= 1'b1;
        2'h3: out_reg <= ~out_reg;
        default: ;
      endcase
    end else if (!run || match_a) begin
      pulse_reg <= 1'b0;
    end
  end

  // Pin driver; timer mode leaves the pin undriven.
  always_comb begin
    timer_output_pin_oe_o = 1'b1;
    case (mode)
      MODE_COMPARE: timer_output_pin_o = out_reg ^ inv;
      MODE_PWM: begin
        case (pin_fn)
          2'h0: timer_output_pin_o = ~olc ^ inv;
          2'h1: timer_output_pin_o = olc ^ inv;
          2'h2: timer_output_pin_o = (pwm_level ? olc : ~olc) ^ inv;
          default: timer_output_pin_o = (pulse_reg ? olc : ~olc) ^ inv;
        endcase
      end
      default: begin
        timer_output_pin_o = 1'b0;
        timer_output_pin_oe_o = 1'b0;
      end
    endcase
  end

  // Read port: data stand in the cycle after the strobe; unused bits read zero.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i && status_sel_i) begin
      rdata_reg <= {6'h00, flag_p_reg, flag_a_reg};
    end else if (rd_i) begin
      case (addr_i)
        REG_CTRL0: rdata_reg <= ctrl0_reg;
        REG_CTRL1: rdata_reg <= ctrl1_reg;
        REG_CNT_LO: rdata_reg <= (mode == MODE_CAPTURE) ? capture_reg[7:0] : count_reg[7:0];
        REG_CNT_HI: rdata_reg <= {6'h00, (mode == MODE_CAPTURE) ? capture_reg[9:8] : count_reg[9:8]};
        REG_CMPA_LO: rdata_reg <= cmp_a_reg[7:0];
        REG_CMPA_HI: rdata_reg <= {6'h00, cmp_a_reg[9:8]};
        REG_CMPP_LO: rdata_reg <= cmp_p_reg[7:0];
        default: rdata_reg <= {6'h00, cmp_p_reg[9:8]};
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_o = rdata_reg;
  assign match_a_flag_o = flag_a_reg;
  assign match_p_flag_o = flag_p_reg;
  assign capture_event_o = mode == MODE_CAPTURE && run && cap_edge;
endmodule // periodic_timer

// *** design/periodic_timer_pkg.sv ***
// Package for the periodic timer: register indices, field positions, resets, mode codes.
// Assumes an eight-bit register port with one-cycle read latency.
package periodic_timer_pkg;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned ADDR_W = 3;
  // Register indices.
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [2:0] REG_CMPP_LO = 3'h6;
  localparam logic [2:0] REG_CMPP_HI = 3'h7;
  localparam logic [2:0] REG_STATUS = 3'h0;
  // Control 0 fields.
  localparam int unsigned HOLD_BIT = 7;
  localparam int unsigned CLKSEL_LSB = 4;
  localparam int unsigned RUN_BIT = 3;
  localparam logic [7:0] CTRL0_MASK = 8'hf8;
  // Control 1 fields.
  localparam int unsigned MODE_LSB = 6;
  localparam int unsigned PINFN_LSB = 4;
  localparam int unsigned OLC_BIT = 3;
  localparam int unsigned INV_BIT = 2;
  localparam int unsigned CAPSRC_BIT = 1;
  localparam int unsigned CLRSRC_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] VAL_RESET = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  // Prescale divider ratios.
  localparam int unsigned DIV_SYS4 = 4;
  localparam int unsigned DIV_H16 = 16;
  localparam int unsigned DIV_H64 = 64;
  localparam int unsigned DIV_SUB = 256;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } op_mode_t;
endpackage

// *** design/pin_edge_sync.sv ***
// Three-stage synchroniser with rising and falling edge pulses.
// Assumes an asynchronous pin input.
`timescale 1ns/1ps
module pin_edge_sync (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic srst_i,
  // Pin and edges.
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  logic [2:0] sync_reg;

  // Only stages two and three are compared; stage one feeds stage two alone.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], pin_i};
    end
  end

  // One pulse per settled edge.
  assign rise_o = sync_reg[1] & ~sync_reg[2];
  assign fall_o = ~sync_reg[1] & sync_reg[2];
endmodule // pin_edge_sync

// *** design/timer_events_if.sv ***
// Interface carrying count enable and pin edge events between timer modules.
// Assumes all users sit on the one system clock.
`timescale 1ns/1ps
interface timer_events_if;
  logic count_tick;
  logic ext_rise;
  logic ext_fall;
  logic cap_rise;
  logic cap_fall;
  modport source (output count_tick, output ext_rise, output ext_fall,
    output cap_rise, output cap_fall);
  modport sink (input count_tick, input ext_rise, input ext_fall,
    input cap_rise, input cap_fall);
endinterface

// *** test/periodic_timer_assertions.sv ***
// Port checker for the periodic timer, bound to its top module.
// Assumes one clock and the active-high synchronous reset of the top.
`timescale 1ns/1ps
module periodic_timer_assertions
  import periodic_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic srst_i,
  // Register port.
  input wire logic [periodic_timer_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic status_sel_i,
  // Pins and events.
  input wire logic ext_clock_pin_i,
  input wire logic capture_pin_i,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_pin_oe_o,
  input wire logic match_a_flag_o,
  input wire logic match_p_flag_o,
  input wire logic capture_event_o
);
  logic hi_rd_q;
  logic c0_rd_q;
  logic st_rd_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Remember which kind of read was taken, so its answer can be judged a cycle later.
  always_ff @(posedge clock_i) begin
    hi_rd_q <= rd_i & ~status_sel_i & (addr_i == REG_CNT_HI);
    c0_rd_q <= rd_i & ~status_sel_i & (addr_i == REG_CTRL0);
    st_rd_q <= rd_i & status_sel_i;
  end
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  chk_count_high: assert property (hi_rd_q |-> rdata_o[7:2] == 6'h00)
    else $error("count high byte upper bits set");
  chk_ctrl0_spare: assert property (c0_rd_q |-> rdata_o[2:0] == 3'h0)
    else $error("control 0 spare bits set");
  chk_status_read: assert property (st_rd_q |->
      rdata_o == {6'h00, $past(match_p_flag_o), $past(match_a_flag_o)})
    else $error("flag register read wrong");
  chk_pin_released: assert property (!timer_output_pin_oe_o |-> !timer_output_pin_o)
    else $error("pin driven while not enabled");
  chk_flag_a_held: assert property (match_a_flag_o && !(wr_i && status_sel_i)
      |=> match_a_flag_o)
    else $error("flag a dropped without a clear");
  chk_flag_p_held: assert property (match_p_flag_o && !(wr_i && status_sel_i)
      |=> match_p_flag_o)
    else $error("flag p dropped without a clear");
  chk_capture_flag: assert property (capture_event_o |-> ##[1:2] match_a_flag_o)
    else $error("capture did not set flag a");
  chk_capture_once: assert property (capture_event_o |=> !capture_event_o)
    else $error("capture pulse longer than one cycle");
  chk_reset_enable: assert property ($fell(srst_i) |-> timer_output_pin_oe_o)
    else $error("pin not enabled after reset");
  cover property (capture_event_o);
  cover property ($rose(match_p_flag_o));
  cover property ($rose(timer_output_pin_o));
endmodule // periodic_timer_assertions

bind periodic_timer periodic_timer_assertions chk (.clock_i(clock_i), .srst_i(srst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .status_sel_i(status_sel_i), .ext_clock_pin_i(ext_clock_pin_i),
  .capture_pin_i(capture_pin_i), .timer_output_pin_o(timer_output_pin_o),
  .timer_output_pin_oe_o(timer_output_pin_oe_o), .match_a_flag_o(match_a_flag_o),
  .match_p_flag_o(match_p_flag_o), .capture_event_o(capture_event_o));

// *** test/periodic_timer_tb.sv ***
// Self-checking bench for the periodic timer top.
// Assumes the pin model drives the external clock and capture pins.
`timescale 1ns/1ps
module periodic_timer_tb;
  import periodic_timer_pkg::*;
  logic clock_i, srst_i, wr_i, rd_i, status_sel_i;
  logic [ADDR_W-1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v1, v2;
  logic pin_o, oe_o, flag_a, flag_p, cap_ev, ext_pin, cap_pin;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_cap = 0;
  periodic_timer dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .status_sel_i(status_sel_i), .ext_clock_pin_i(ext_pin), .capture_pin_i(cap_pin),
    .timer_output_pin_o(pin_o), .timer_output_pin_oe_o(oe_o), .match_a_flag_o(flag_a),
    .match_p_flag_o(flag_p), .capture_event_o(cap_ev));
  pin_source_model pins (.clock_i(clock_i), .ext_clock_pin_o(ext_pin),
    .capture_pin_o(cap_pin));
  // System clock at 200 MHz.
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Capture pulses are counted here; the cycle ceiling cuts a hang short.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cap_ev === 1'b1) n_cap <= n_cap + 1;
    if (cycles == 40000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic s = 1'b0);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    status_sel_i <= s;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] d, input logic s = 1'b0);
    @(posedge clock_i);
    addr_i <= a;
    status_sel_i <= s;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // The timer is switched off before any mode or pin function change.
  task automatic setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
    wr(REG_CTRL0, 8'h00);
    wr(REG_STATUS, 8'h03, 1'b1);
    wr(REG_CTRL1, c1);
    wr(REG_CMPA_LO, a[7:0]);
    wr(REG_CMPA_HI, {6'h00, a[9:8]});
    wr(REG_CMPP_LO, p[7:0]);
    wr(REG_CMPP_HI, {6'h00, p[9:8]});
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], v1);
      check("reset value", v1, 10'h000);
    end
    check("pin enable", oe_o, 10'h001);
  endtask
  task automatic t_regs();
    wr(REG_CTRL0, 8'hff);
    wr(REG_CNT_LO, 8'h55);
    rd(REG_CTRL0, v1);
    check("control 0", v1, CTRL0_MASK);
    rd(REG_CNT_LO, v1);
    check("count write", v1, 10'h000);
    wr(REG_CMPA_HI, 8'hff);
    rd(REG_CMPA_HI, v1);
    check("compare a high", v1, 10'h003);
    wr(REG_CTRL0, 8'h00);
    wr(REG_CTRL1, 8'ha5);
    rd(REG_CTRL1, v1);
    check("control 1", v1, 10'h0a5);
  endtask
  task automatic t_compare();
    logic [7:0] c1s [6] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h19, 8'h35};
    logic [1:0] ex [6] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b10, 2'b10};
    for (int i = 0; i < 6; i++) begin
      setup(c1s[i], 10'd20, 10'd3);
      wr(REG_CTRL0, 8'h18);
      repeat (4) @(posedge clock_i);
      #1;
      check("initial pin", pin_o, ex[i][1]);
      repeat (30) @(posedge clock_i);
      #1;
      check("matched pin", pin_o, ex[i][0]);
      check("flag a", flag_a, 10'h001);
      check("flag p", flag_p, 10'h000);
    end
  endtask
  task automatic t_hold();
    setup(8'hfc, 10'd0, 10'd0);
    wr(REG_CTRL0, 8'h18);
    check("timer pin", {oe_o, pin_o}, 10'h000);
    wr(REG_CTRL0, 8'h98);
    rd(REG_CNT_LO, v1);
    repeat (10) @(posedge clock_i);
    rd(REG_CNT_LO, v2);
    check("held count", v2, v1);
    wr(REG_CTRL0, 8'h18);
    rd(REG_CNT_LO, v2);
    // One tick lands between the write that releases hold and the read strobe.
    check("resumed", v2, v1 + 8'h01);
    wr(REG_CTRL0, 8'h10);
    rd(REG_CNT_LO, v1);
    repeat (10) @(posedge clock_i);
    rd(REG_CNT_LO, v2);
    check("stopped count", v2, v1);
    wr(REG_CTRL0, 8'h18);
    rd(REG_CNT_LO, v2);
    check("restart zero", v2, 10'h000);
    repeat (1100) @(posedge clock_i);
    check("overflow p", {flag_p, flag_a}, 10'h002);
    rd(REG_STATUS, v1, 1'b1);
    check("flag register", v1, 10'h002);
    wr(REG_STATUS, 8'h02, 1'b1);
    #1;
    check("flag clear", flag_p, 10'h000);
  endtask
  task automatic t_clksel();
    int divs [6] = '{DIV_SYS4, 1, DIV_H16, DIV_H64, DIV_SUB, DIV_SUB};
    int d;
    for (int s = 0; s < 6; s++) begin
      setup(8'hc0, 10'd0, 10'd0);
      wr(REG_CTRL0, {1'b0, s[2:0], 4'h8});
      repeat (200) @(posedge clock_i);
      rd(REG_CNT_LO, v1);
      // Prescaler phase is unseen, so allow one tick either way.
      d = int'(v1) - 200 / divs[s];
      check("clock select", d inside {[-1:1]}, 10'h001);
    end
  endtask
  task automatic t_ext();
    for (int e = 0; e < 2; e++) begin
      setup(8'hc0, 10'd0, 10'd0);
      wr(REG_CTRL0, e ? 8'h78 : 8'h68);
      pins.pulse(0, 5);
      repeat (10) @(posedge clock_i);
      rd(REG_CNT_LO, v1);
      check("external edges", v1, 10'h005);
    end
  endtask
  task automatic t_capture();
    logic [7:0] c1s [5] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h42};
    int src [5] = '{1, 1, 1, 1, 0};
    int ex [5] = '{1, 1, 2, 0, 1};
    int n0;
    for (int i = 0; i < 5; i++) begin
      setup(c1s[i], 10'd0, 10'd0);
      wr(REG_CTRL0, 8'h18);
      n0 = n_cap;
      pins.pulse(src[i], 1);
      repeat (10) @(posedge clock_i);
      check("captures", 10'(n_cap - n0), 10'(ex[i]));
      check("capture flag", flag_a, ex[i] != 0);
    end
  endtask
  task automatic t_pwm();
    logic [7:0] c1s [6] = '{8'ha8, 8'ha8, 8'h88, 8'h98, 8'ha0, 8'hac};
    int a [6] = '{4, 12, 4, 4, 4, 4};
    int ex [6] = '{40, 100, 0, 100, 60, 60};
    int hi;
    for (int i = 0; i < 6; i++) begin
      setup(c1s[i], 10'(a[i]), 10'd10);
      wr(REG_CTRL0, 8'h18);
      repeat (30) @(posedge clock_i);
      hi = 0;
      repeat (100) begin
        @(posedge clock_i);
        if (pin_o === 1'b1) hi++;
      end
      check("pwm high cycles", 10'(hi), 10'(ex[i]));
    end
  endtask
  task automatic t_single();
    setup(8'hb8, 10'd20, 10'd0);
    wr(REG_CTRL0, 8'h18);
    repeat (4) @(posedge clock_i);
    #1;
    check("pulse lead", pin_o, 10'h001);
    repeat (40) @(posedge clock_i);
    #1;
    check("pulse trail", pin_o, 10'h000);
    rd(REG_CTRL0, v1);
    check("run cleared", v1[RUN_BIT], 10'h000);
  endtask
  // Main sequence, ending with a second reset in mid-run.
  initial begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    status_sel_i = 1'b0;
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_regs();
    t_compare();
    t_hold();
    t_clksel();
    t_ext();
    t_capture();
    t_pwm();
    t_single();
    wr(REG_CTRL0, 8'h18);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    print_verdict();
  end
endmodule // periodic_timer_tb

// *** test/pin_source_model.sv ***
// Model of the outside pins: external clock source and capture source.
// Assumes the bench calls its task from one thread on the system clock.
`timescale 1ns/1ps
module pin_source_model (
  // Clock.
  input wire logic clock_i,
  // Pins.
  output logic ext_clock_pin_o,
  output logic capture_pin_o
);
  logic [1:0] pin_q = 2'b00;
  // Both pins rest low between pulses.
  assign ext_clock_pin_o = pin_q[0];
  assign capture_pin_o = pin_q[1];
  // The high level is held eight cycles and the low at least eight, well beyond the synchroniser depth.
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge clock_i);
      pin_q[which] <= 1'b1;
      repeat (8) @(posedge clock_i);
      pin_q[which] <= 1'b0;
      repeat (8) @(posedge clock_i);
    end
  endtask
endmodule // pin_source_model
